// ==== core/pmrc_pkg.sv ====
// Constants, types and field layouts of the pixel matrix readout control.
// Assumes one 100 MHz clock domain; every pin is synchronised before use.
//
// Function
// - Direct mode selects one pixel by 9-bit column and line indices.
// - Standard modes scan each cluster line by line, 8 or 16 in parallel.
// - Column token recirculates left to right on the readout clock.
// - Line token per cluster advances when the column token wraps.
// - Read input loads the initial tokens before scanning starts.
// - Region mode works only with the self-trigger enabled.
// - Hit rectangle is widened by 10 pixels, or 20 with wide margin.
// - Region mode scans the widened rectangle as one cluster.
// - Corners are presented after acquisition and marked by the valid flag.
// - Write mode picks one pixel, odd columns, even columns or all.
// - Test charge is injected on the rising edge of the write input.
// - Mask input disables the addressed pixel; both modes must be 00.
// - Enable-all input clears every pixel trigger-disable bit.
// - Load-default sets modes 00, enables 0 and both indices 511.
// - Trigger output is driven only with the self-trigger enabled.
// - Column position advances on each falling readout clock edge.
// - Done flag rises at scan end in read modes 01, 10 and 11.
// - Analog clear returns pixels to tracking and clears trigger latches.
// - Serial data sampled on falling serial clock, changed on rising.
// - Load strobes copy the serial register to settings or address.
// - Fetch strobes copy settings or corners into the serial register.
package pmrc_pkg;
   // --------------------------------------------------------------------
   // Matrix geometry and counts
   // --------------------------------------------------------------------
   localparam int         NCOL        = 300;
   localparam int         NLINE       = 352;
   localparam int         NBUF        = 16;
   localparam logic [8:0] COL_LAST    = 9'h12b;  // Column 299.
   localparam logic [8:0] LINE_LAST   = 9'h15f;  // Line 351.
   localparam logic [8:0] H_CLUS8     = 9'h02c;  // 44 lines a cluster.
   localparam logic [8:0] H_CLUS16    = 9'h016;  // 22 lines a cluster.
   localparam logic [8:0] MARGIN_NARROW = 9'h00a;
   localparam logic [8:0] MARGIN_WIDE   = 9'h014;
   localparam logic [8:0] ADDR_DEFAULT  = 9'h1ff;
   localparam int         SREG_W      = 36;
   localparam int         NPIN        = 32;
   // --------------------------------------------------------------------
   // APB register offsets and reset values
   // --------------------------------------------------------------------
   localparam logic [11:0] OFS_SETTINGS = 12'h000;
   localparam logic [11:0] OFS_ADDRESS  = 12'h004;
   localparam logic [11:0] OFS_STATUS   = 12'h008;
   localparam logic [11:0] OFS_CORNERS  = 12'h00c;

   typedef enum logic [1:0] {RM_DIRECT, RM_CLUS8, RM_CLUS16, RM_ROI}
      pmrc_rmode_e;
   typedef enum logic [1:0] {SC_IDLE, SC_SCAN, SC_DONE} pmrc_scan_e;

   typedef struct packed {
      pmrc_rmode_e read_mode;
      logic [1:0]  write_mode_select;
      logic        self_trigger_enable;
      logic        wide_margin_select;
   } pmrc_cfg_s;

   typedef struct packed {
      logic [8:0] col;
      logic [8:0] line;
   } pmrc_addr_s;

   typedef struct packed {
      logic [8:0] xmin;
      logic [8:0] ymin;
      logic [8:0] xmax;
      logic [8:0] ymax;
   } pmrc_corner_s;

   // Synchronised pin group, one bit or field per pin.
   typedef struct packed {
      logic       sck;
      logic       serial_in;
      logic       copy_to_settings;
      logic       copy_to_address;
      logic       fetch_settings;
      logic       fetch_roi_corners;
      logic       load_default_settings;
      logic       enable_all_pixel_trigger;
      logic       pixel_mask_strobe;
      logic       test_write;
      logic       read_start;
      logic       column_step_clock;
      logic       analog_memory_clear;
      logic       trigger_gate_window;
      logic [8:0] hit_col;
      logic [8:0] hit_line;
   } pmrc_pins_s;

   localparam pmrc_cfg_s  CFG_RESET  = '{RM_DIRECT, 2'h0, 1'b0, 1'b0};
   localparam pmrc_addr_s ADDR_RESET = '{ADDR_DEFAULT, ADDR_DEFAULT};
endpackage

// ==== core/pmrc_sync.sv ====
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the group's bits change slowly against the sampling clock.
`timescale 1ns/1ns
`default_nettype none
module pmrc_sync
#(
   parameter int W = 1
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   // The first stage feeds only the second; metastability settles there.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1   <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // pmrc_sync
`default_nettype wire

// ==== core/pmrc_top.sv ====
// Digital readout control of the pixel matrix: settings, serial port,
// token scan, region of interest, injection and mask strobes, APB view.
// Assumes pins are asynchronous and the matrix decodes the select outputs.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module pmrc_top
   import pmrc_pkg::*;
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          sck,
   input  wire logic          serial_in,
   input  wire logic          copy_to_settings,
   input  wire logic          copy_to_address,
   input  wire logic          fetch_settings,
   input  wire logic          fetch_roi_corners,
   input  wire logic          load_default_settings,
   input  wire logic          enable_all_pixel_trigger,
   input  wire logic          pixel_mask_strobe,
   input  wire logic          test_write,
   input  wire logic          read_start,
   input  wire logic          column_step_clock,
   input  wire logic          analog_memory_clear,
   input  wire logic          trigger_gate_window,
   input  wire logic          hit_valid,
   input  wire logic [8:0]    hit_col,
   input  wire logic [8:0]    hit_line,
   output logic               serial_out,
   output logic               trigger_pulse_out,
   output logic               readout_done_flag,
   output logic               roi_valid_flag,
   output logic [NCOL-1:0]    col_select,
   output logic [NLINE-1:0]   line_select,
   output logic [NBUF-1:0]    buffer_enable,
   output logic               inject_pulse,
   output logic [1:0]         inject_mode,
   output logic [8:0]         pixel_col,
   output logic [8:0]         pixel_line,
   output logic               mask_pulse,
   output logic               unmask_all_pulse,
   output logic               analog_clear_pulse
);
   // --------------------------------------------------------------------
   // Pin synchronisation and edge detection
   // --------------------------------------------------------------------
   pmrc_pins_s raw_pins, pin, pin_d;
   logic       hit_s, hit_d;
   assign raw_pins = '{sck, serial_in, copy_to_settings, copy_to_address,
                       fetch_settings, fetch_roi_corners,
                       load_default_settings, enable_all_pixel_trigger,
                       pixel_mask_strobe, test_write, read_start,
                       column_step_clock, analog_memory_clear,
                       trigger_gate_window, hit_col, hit_line};

   // Hit coordinates ride with their strobe; they must be stable meanwhile.
   pmrc_sync #(.W(NPIN + 1)) u_sync
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({raw_pins, hit_valid}),
      .sync_out ({pin, hit_s})
   );

   // Delayed copies give the edges of every synchronised pin.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_d <= '0;
         hit_d <= 1'b0;
      end
      else
      begin
         pin_d <= pin;
         hit_d <= hit_s;
      end
   end

   pmrc_pins_s rise, fall;
   logic       hit_rise;
   assign rise     = pin & ~pin_d;
   assign fall     = ~pin & pin_d;
   assign hit_rise = hit_s & ~hit_d;

   // --------------------------------------------------------------------
   // Settings and address registers
   // --------------------------------------------------------------------
   pmrc_cfg_s    cfg;
   pmrc_addr_s   addr;
   pmrc_corner_s corners;
   logic [SREG_W-1:0] sreg;
   logic         apb_wr;
   assign apb_wr = psel & penable & pready & pwrite;

   // Default load wins over the serial copy, which wins over the bus.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg  <= CFG_RESET;
         addr <= ADDR_RESET;
      end
      else if (rise.load_default_settings)
      begin
         cfg  <= CFG_RESET;
         addr <= ADDR_RESET;
      end
      else
      begin
         if (rise.copy_to_settings)
            cfg <= pmrc_cfg_s'(sreg[5:0]);
         else if (apb_wr && paddr == OFS_SETTINGS)
            cfg <= pmrc_cfg_s'(pwdata[5:0]);
         if (rise.copy_to_address)
            addr <= pmrc_addr_s'(sreg[17:0]);
         else if (apb_wr && paddr == OFS_ADDRESS)
            addr <= pmrc_addr_s'(pwdata[17:0]);
      end
   end

   // --------------------------------------------------------------------
   // Serial shift register
   // --------------------------------------------------------------------
   // Sampling on the falling edge leaves half a period of setup after the
   // output change on the rising edge.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sreg <= '0;
      else if (rise.fetch_settings)
         sreg <= {30'h0, cfg};
      else if (rise.fetch_roi_corners)
         sreg <= corners;
      else if (fall.sck)
         sreg <= {sreg[SREG_W-2:0], pin.serial_in};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         serial_out <= 1'b0;
      else if (rise.sck)
         serial_out <= sreg[SREG_W-1];
   end

   // --------------------------------------------------------------------
   // Region of interest
   // --------------------------------------------------------------------
   pmrc_corner_s ext;
   logic         hit_seen;
   logic [8:0]   margin;
   assign margin = cfg.wide_margin_select ? MARGIN_WIDE : MARGIN_NARROW;

   // Extents grow with each latched hit; a set beats a same-cycle clear.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext            <= '{9'h1ff, 9'h1ff, 9'h000, 9'h000};
         hit_seen       <= 1'b0;
         corners        <= '0;
         roi_valid_flag <= 1'b0;
      end
      else
      begin
         if (rise.analog_memory_clear)
         begin
            ext            <= '{9'h1ff, 9'h1ff, 9'h000, 9'h000};
            hit_seen       <= 1'b0;
            roi_valid_flag <= 1'b0;
         end
         if (hit_rise && cfg.self_trigger_enable && pin.trigger_gate_window)
         begin
            hit_seen <= 1'b1;
            if (pin.hit_col < ext.xmin)
               ext.xmin <= pin.hit_col;
            if (pin.hit_line < ext.ymin)
               ext.ymin <= pin.hit_line;
            if (pin.hit_col > ext.xmax)
               ext.xmax <= pin.hit_col;
            if (pin.hit_line > ext.ymax)
               ext.ymax <= pin.hit_line;
         end
         // Acquisition ends when the gate closes after a trigger.
         if (fall.trigger_gate_window && hit_seen)
         begin
            corners.xmin <= (ext.xmin < margin) ? 9'h000
                            : ext.xmin - margin;
            corners.ymin <= (ext.ymin < margin) ? 9'h000
                            : ext.ymin - margin;
            corners.xmax <= (ext.xmax > COL_LAST - margin) ? COL_LAST
                            : ext.xmax + margin;
            corners.ymax <= (ext.ymax > LINE_LAST - margin) ? LINE_LAST
                            : ext.ymax + margin;
            roi_valid_flag <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------------
   // Token scan
   // --------------------------------------------------------------------
   pmrc_scan_e state;
   logic [8:0] col_pos, line_pos, col_first, col_end, line_first, line_end;
   logic       roi_ok;
   assign roi_ok = cfg.self_trigger_enable;

   // Scan bounds per read mode; region mode uses the widened rectangle.
   always_comb
   begin
      col_first  = 9'h000;
      col_end    = COL_LAST;
      line_first = 9'h000;
      line_end   = H_CLUS16 - 9'h001;
      case (cfg.read_mode)
         RM_CLUS8:
            line_end = H_CLUS8 - 9'h001;
         RM_ROI:
         begin
            col_first  = corners.xmin;
            col_end    = corners.xmax;
            line_first = corners.ymin;
            line_end   = corners.ymax;
         end
         default:
            line_end = H_CLUS16 - 9'h001;
      endcase
   end

   // Read loads the tokens; each falling readout clock steps the column.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state             <= SC_IDLE;
         col_pos           <= '0;
         line_pos          <= '0;
         readout_done_flag <= 1'b0;
      end
      else if (rise.read_start)
      begin
         col_pos           <= col_first;
         line_pos          <= line_first;
         readout_done_flag <= 1'b0;
         if (cfg.read_mode != RM_DIRECT &&
             (cfg.read_mode != RM_ROI || roi_ok))
            state <= SC_SCAN;
      end
      else if (!pin.read_start)
         state <= SC_IDLE;
      else
      begin
         case (state)
            SC_SCAN:
               if (fall.column_step_clock)
               begin
                  if (col_pos != col_end)
                     col_pos <= col_pos + 9'h001;
                  else
                  begin
                     col_pos <= col_first;
                     if (line_pos != line_end)
                        line_pos <= line_pos + 9'h001;
                     else
                     begin
                        state             <= SC_DONE;
                        readout_done_flag <= 1'b1;
                     end
                  end
               end
            default:
               state <= state;
         endcase
      end
   end

   // Select lines from flops: one pixel in direct mode, tokens otherwise.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         col_select  <= '0;
         line_select <= '0;
      end
      else
      begin
         for (int i = 0; i < NCOL; i++)
            col_select[i] <= pin.read_start &&
               ((cfg.read_mode == RM_DIRECT) ? addr.col == 9'(i)
                : (state == SC_SCAN && col_pos == 9'(i)));
         for (int l = 0; l < NLINE; l++)
         begin
            case (cfg.read_mode)
               RM_DIRECT:
                  line_select[l] <= pin.read_start
                                    && addr.line == 9'(l);
               RM_CLUS8:
                  line_select[l] <= state == SC_SCAN
                                    && line_pos == 9'(l % 44);
               RM_CLUS16:
                  line_select[l] <= state == SC_SCAN
                                    && line_pos == 9'(l % 22);
               default:
                  line_select[l] <= state == SC_SCAN
                                    && line_pos == 9'(l);
            endcase
         end
      end
   end

   // --------------------------------------------------------------------
   // Strobes toward the matrix
   // --------------------------------------------------------------------
   // Mask bits live in the pixels and are lost at power-up; only the
   // controller can restore them.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trigger_pulse_out  <= 1'b0;
         inject_pulse       <= 1'b0;
         inject_mode        <= 2'h0;
         mask_pulse         <= 1'b0;
         unmask_all_pulse   <= 1'b0;
         analog_clear_pulse <= 1'b0;
         buffer_enable      <= '0;
         pixel_col          <= ADDR_DEFAULT;
         pixel_line         <= ADDR_DEFAULT;
      end
      else
      begin
         trigger_pulse_out  <= cfg.self_trigger_enable & hit_s
                               & pin.trigger_gate_window;
         inject_pulse       <= rise.test_write;
         inject_mode        <= cfg.write_mode_select;
         mask_pulse         <= rise.pixel_mask_strobe
                               && cfg.read_mode == RM_DIRECT
                               && cfg.write_mode_select == 2'h0;
         unmask_all_pulse   <= rise.enable_all_pixel_trigger;
         analog_clear_pulse <= rise.analog_memory_clear;
         pixel_col          <= addr.col;
         pixel_line         <= addr.line;
         case (cfg.read_mode)
            RM_CLUS8:  buffer_enable <= 16'h00ff;
            RM_CLUS16: buffer_enable <= 16'hffff;
            default:   buffer_enable <= 16'h0001;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // APB slave, one wait state
   // --------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && penable && !pready)
         begin
            if (paddr == OFS_SETTINGS)
               prdata <= {26'h0, cfg};
            else if (paddr == OFS_ADDRESS)
               prdata <= {14'h0, addr};
            else if (paddr == OFS_STATUS)
               prdata <= {11'h0, line_pos, col_pos,
                          state == SC_SCAN, roi_valid_flag,
                          readout_done_flag};
            else if (paddr == OFS_CORNERS)
               prdata <= {28'h0, corners[35:32]};
            else
               pslverr <= 1'b1;
         end
      end
   end

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_default_load;
      rise.load_default_settings;
   endsequence

   a_default_load_values: assert property (s_default_load |=>
      cfg == CFG_RESET && addr == ADDR_RESET)
      else $error("load default did not restore settings");
   a_trigger_out_gated: assert property (trigger_pulse_out |->
      $past(cfg.self_trigger_enable))
      else $error("trigger out without self-trigger enable");
   a_done_mode_set: assert property ($rose(readout_done_flag) |->
      $past(cfg.read_mode) != RM_DIRECT)
      else $error("done flag raised in direct mode");
   a_mask_modes_zero: assert property (mask_pulse |->
      $past(cfg.read_mode) == RM_DIRECT
      && $past(cfg.write_mode_select) == 2'h0)
      else $error("mask strobe with modes not zero");
   a_buffer_count: assert property ($past(presetn) |->
      $countones(buffer_enable) ==
      (($past(cfg.read_mode) == RM_CLUS8) ? 8
       : ($past(cfg.read_mode) == RM_CLUS16) ? 16 : 1))
      else $error("wrong number of buffers enabled");
   a_inject_on_rise: assert property ($rose(pin.test_write) |=>
      inject_pulse ##1 !inject_pulse)
      else $error("injection not a single pulse on write rise");
   a_roi_needs_self: assert property (rise.read_start
      && cfg.read_mode == RM_ROI && !cfg.self_trigger_enable
      |=> state != SC_SCAN)
      else $error("region scan started without self-trigger");
   a_serial_out_rise: assert property ($changed(serial_out) |->
      $past(rise.sck))
      else $error("serial out changed off a rising serial clock");
   a_margin_min: assert property ($rose(roi_valid_flag) |->
      corners.xmin == (($past(ext.xmin) < $past(margin)) ? 9'h000
                       : $past(ext.xmin) - $past(margin)))
      else $error("region margin wrong");
   a_column_step: assert property (state == SC_SCAN
      && fall.column_step_clock && col_pos != col_end && pin.read_start
      |=> col_pos == $past(col_pos) + 9'h001)
      else $error("column did not advance on falling clock");
endmodule // pmrc_top
`default_nettype wire

// ==== dv/pmrc_ctrl_model.sv ====
// Acquisition controller model: drives the serial link of the block.
// Assumes the block samples serial_in on the falling edge of sck.
`timescale 1ns/1ns
`default_nettype none
module pmrc_ctrl_model
(
   output logic      sck,
   output logic      serial_in,
   input  wire logic serial_out
);
   // The serial clock stands low between frames.
   initial
   begin
      sck = 1'b0;
      serial_in = 1'b0;
   end
   // Shifts one 36-bit word MSB first at an 80 ns bit period; the returned
   // bit is taken just before each falling edge, when it has settled.
   task automatic shift(input logic [35:0] v, output logic [35:0] q);
      for (int i = 35; i >= 0; i--)
      begin
         sck <= 1'b1;
         serial_in <= v[i];
         #40;
         q[i] = serial_out;
         sck <= 1'b0;
         #40;
      end
      serial_in <= ~v[0]; // Stale data must not look valid.
   endtask
endmodule // pmrc_ctrl_model
`default_nettype wire

// ==== dv/pmrc_top_test.sv ====
// Self-checking bench of the readout control block.
// Assumes the controller model drives the serial link pins.
`timescale 1ns/1ns
`default_nettype none
module pmrc_top_test;
   import pmrc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, rd, ck, gate, hv, e, sk, sd;
   logic so, dn;
   logic [11:0] paddr;
   logic [31:0] pwdata, r, prdata;
   logic [8:0] stb, po;
   logic [35:0] q;
   logic [NLINE-1:0] ls;
   logic [15:0] buffer_enable;
   logic [NCOL-1:0] col_select;
   logic [8:0] pixel_col, pixel_line;
   logic pready, pslverr, trg, roi;
   int n_mismatch, samples_checked;
   logic [15:0] bufexp [4] = '{16'h0001, 16'h00ff, 16'hffff, 16'h0001};
   pmrc_ctrl_model ctrl_u (.sck(sk), .serial_in(sd), .serial_out(so));
   pmrc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sck(sk), .serial_in(sd),
      .copy_to_settings(stb[0]), .copy_to_address(stb[1]),
      .load_default_settings(stb[2]), .pixel_mask_strobe(stb[3]),
      .test_write(stb[4]), .enable_all_pixel_trigger(stb[5]),
      .analog_memory_clear(stb[6]), .fetch_settings(stb[7]),
      .fetch_roi_corners(stb[8]), .read_start(rd), .column_step_clock(ck),
      .trigger_gate_window(gate), .hit_valid(hv), .hit_col(9'd100),
      .hit_line(9'd50), .serial_out(so), .trigger_pulse_out(trg),
      .readout_done_flag(dn), .roi_valid_flag(roi), .col_select,
      .line_select(ls), .buffer_enable, .inject_pulse(po[4]), .inject_mode(),
      .pixel_col, .pixel_line, .mask_pulse(po[3]),
      .unmask_all_pulse(po[5]), .analog_clear_pulse(po[6]));
   assign {po[8:7], po[2:0]} = 5'h0;
   // Clock generation.
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic complete_run;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [35:0] x, g);
      samples_checked++;
      if (g !== x)
      begin
         $display("ERROR %s expected %h seen %h", nm, x, g);
         n_mismatch++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One readout clock period of 80 ns; the column steps on its fall.
   task automatic step();
      ck <= 1'b1;
      cyc(4);
      ck <= 1'b0;
      cyc(4);
   endtask
   // One APB transfer; waits for pready under a bounded count.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
      if (n == 20)
      begin
         n_mismatch++;
         complete_run();
      end
   endtask
   // Strobes a pin long enough to pass the synchroniser; notes its pulse.
   task automatic pulse(input int b, input logic x);
      logic s;
      s = 1'b0;
      stb[b] <= 1'b1;
      repeat (5) @(posedge pclk) s |= po[b];
      stb[b] <= 1'b0;
      repeat (5) @(posedge pclk) s |= po[b];
      if (b > 2 && b < 7) chk("strobe out", {31'h0, x}, {31'h0, s});
   endtask
   // Main sequence.
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, stb, rd, ck, gate, hv} = '0;
      presetn = 1'b0;
      cyc(6);
      presetn <= 1'b1;
      cyc(1);
      apb(0, OFS_SETTINGS, 0); chk("settings", 32'h0, r);
      apb(0, OFS_ADDRESS, 0); chk("address", 32'h3ffff, r);
      apb(1, 12'h010, 32'h3f); chk("pslverr", 32'h1, {31'h0, e});
      for (int m = 0; m < 4; m++)
      begin
         apb(1, OFS_SETTINGS, 32'(m) << 4);
         cyc(3);
         chk("buffers", {16'h0, bufexp[m]}, {16'h0, buffer_enable});
      end
      apb(1, OFS_SETTINGS, 32'h0); gate <= 1'b1; hv <= 1'b1; cyc(8);
      chk("trigger off", 32'h0, {31'h0, trg});
      apb(1, OFS_SETTINGS, 32'h2); hv <= 1'b0; cyc(4); hv <= 1'b1; cyc(8);
      chk("trigger on", 32'h1, {31'h0, trg});
      hv <= 1'b0; cyc(4); gate <= 1'b0; cyc(10);
      chk("roi valid", 32'h1, {31'h0, roi});
      apb(0, OFS_CORNERS, 0); chk("xmin high", 32'h2, r & 32'hf);
      pulse(6, 1'b1); chk("roi clear", 32'h0, {31'h0, roi});
      apb(1, OFS_SETTINGS, 32'h10); rd <= 1'b1; cyc(8);
      chk("token load", 32'h1, {30'h0, col_select[1:0]});
      chk("line tokens", 32'h3, {30'h0, ls[44], ls[0]});
      step(); cyc(4);
      chk("column step", 32'h2, {30'h0, col_select[1:0]});
      rd <= 1'b0;
      ctrl_u.shift({18'h0, 9'd5, 9'd7}, q); pulse(1, 1'b0);
      chk("pixel", {14'h0, 9'd5, 9'd7}, {14'h0, pixel_col, pixel_line});
      ctrl_u.shift(36'h20, q); pulse(0, 1'b0);
      apb(0, OFS_SETTINGS, 0); chk("serial settings", 32'h20, r);
      pulse(8, 1'b0); ctrl_u.shift(36'h0, q);
      chk("corners out", {9'd90, 9'd40, 9'd110, 9'd60}, q);
      pulse(7, 1'b0); ctrl_u.shift(36'h0, q);
      chk("settings out", 36'h20, q);
      pulse(2, 1'b0); apb(0, OFS_SETTINGS, 0);
      chk("default", 32'h0, r | {23'h0, pixel_col} ^ 32'h1ff);
      pulse(3, 1'b1);
      pulse(4, 1'b1);
      pulse(5, 1'b1);
      apb(1, OFS_SETTINGS, 32'h32); rd <= 1'b1; cyc(8);
      repeat (440) step();
      chk("done early", 32'h0, {31'h0, dn});
      step(); cyc(2);
      chk("done", 32'h1, {31'h0, dn});
      complete_run();
   end
endmodule // pmrc_top_test
`default_nettype wire
